// [core/bea_consts.svh]
// Constants for the byte EEPROM access control block.
`ifndef BEA_CONSTS_SVH
`define BEA_CONSTS_SVH

// Register byte offsets on the bus.
`define BEA_OFF_CTRL 8'h00
`define BEA_OFF_PTR 8'h04
`define BEA_OFF_VALUE 8'h08

// Control register field positions.
`define BEA_BIT_READ 0
`define BEA_BIT_START 1
`define BEA_BIT_UNLOCK 2
`define BEA_BIT_IRQ_EN 3
`define BEA_BIT_MODE_LO 4
`define BEA_BIT_MODE_HI 5

// Mode codes.
`define BEA_MODE_ATOMIC 2'h0
`define BEA_MODE_ERASE 2'h1
`define BEA_MODE_WRITE 2'h2
`define BEA_MODE_RSVD 2'h3

// Reset and erased values.
`define BEA_MODE_RESET 2'h0
`define BEA_ERASED_BYTE 8'hff

// Timing: core stalls and unlock window in cycles.
`define BEA_STALL_PROG 3'h2
`define BEA_STALL_READ 3'h4
`define BEA_UNLOCK_WINDOW 3'h4

// Programming times in microseconds, clock in MHz.
`define BEA_ATOMIC_TIME_US 3400
`define BEA_SINGLE_TIME_US 1800
`define BEA_CLK_MHZ 125
`define BEA_ATOMIC_TICKS (`BEA_ATOMIC_TIME_US * `BEA_CLK_MHZ)
`define BEA_SINGLE_TICKS (`BEA_SINGLE_TIME_US * `BEA_CLK_MHZ)

// Bus responses.
`define BEA_RESP_OKAY 2'h0
`define BEA_RESP_SLVERR 2'h2

`endif

// [core/bea_pkg.sv]
// Types shared by the byte EEPROM access control block.
`default_nettype none
package bea_pkg;
  // Programming engine states, one-hot.
  typedef enum logic [1:0] {
    BEA_ENG_IDLE = 2'b01,
    BEA_ENG_RUN = 2'b10
  } bea_eng_state_t;
  // Programming mode code.
  typedef logic [1:0] bea_mode_t;
endpackage
`default_nettype wire

// [core/bea_top.sv]
// Byte EEPROM access control with an AXI4-Lite register slave.
`include "bea_consts.svh"
`default_nettype none
module bea_top #(
  parameter int ADDR_W = 6,
  parameter int ATOMIC_TICKS = `BEA_ATOMIC_TICKS,
  parameter int SINGLE_TICKS = `BEA_SINGLE_TICKS
) (
  // Clock, resets and clock enable.
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic I_PWR_NRST,
  input wire logic I_CLK_EN,
  // Calibrated oscillator tick, one pulse per period.
  input wire logic I_OSC_TICK,
  // AXI4-Lite write address channel.
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  // AXI4-Lite write data channel.
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response channel.
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read address channel.
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  // AXI4-Lite read data channel.
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Core side status.
  output logic O_CPU_STALL,
  output logic O_BUSY,
  output logic O_READY_IRQ
);
  import bea_pkg::*;

  // The tick counter is 20 bits wide; longer times cannot be served.
  if (ATOMIC_TICKS < 1 || ATOMIC_TICKS >= 2**20 ||
      SINGLE_TICKS < 1 || SINGLE_TICKS >= 2**20 ||
      ADDR_W < 1 || ADDR_W > 8) begin : g_chk
    $error("bea_top: parameter out of range");
  end

  localparam int DEPTH = 2**ADDR_W;

  // Byte storage of the nonvolatile array.
  logic [7:0] mem [DEPTH];
  // Software visible registers.
  logic [ADDR_W-1:0] byte_pointer_reg;
  logic [7:0] byte_value_reg;
  bea_mode_t program_mode_bits;
  logic ready_irq_enable;
  // Unlock window countdown; unlock bit reads set while nonzero.
  logic [2:0] unlock_cnt;
  // Core stall countdown.
  logic [2:0] stall_cnt;
  // Programming engine.
  bea_eng_state_t eng_state;
  logic [19:0] tick_cnt;
  bea_mode_t run_mode;
  logic [ADDR_W-1:0] run_ptr;
  logic [7:0] run_data;
  // Bus holding registers.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  // Decode of a bus offset, used on both the read and write paths.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `BEA_OFF_CTRL) || (a == `BEA_OFF_PTR) ||
             (a == `BEA_OFF_VALUE);
  endfunction

  // Combined terms of the write path.
  logic busy;
  logic wr_fire;
  logic ctrl_wr;
  logic start_req;
  logic read_req;
  assign busy = (eng_state == BEA_ENG_RUN);
  assign wr_fire = I_CLK_EN && aw_held && w_held && !O_BVALID;
  assign ctrl_wr = wr_fire && w_lane0 && (aw_addr == `BEA_OFF_CTRL);
  // Start needs an unlock from an earlier write, an idle engine and a
  // defined mode; otherwise it is dropped silently.
  assign start_req = ctrl_wr && w_byte[`BEA_BIT_START] &&
                     (unlock_cnt != 3'h0) && !busy &&
                     (program_mode_bits != `BEA_MODE_RSVD);
  assign read_req = ctrl_wr && w_byte[`BEA_BIT_READ] && !busy;

  // Write address and data are taken independently in either order.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
    end else if (I_CLK_EN) begin
      // Ready is offered one cycle, only while its own channel holds nothing.
      O_AWREADY <= !aw_held && !O_AWREADY && I_AWVALID;
      O_WREADY <= !w_held && !O_WREADY && I_WVALID;
      if (I_AWVALID && O_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {I_AWADDR[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_held <= 1'b1;
        w_byte <= I_WDATA[7:0];
        w_lane0 <= I_WSTRB[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response follows once both halves are in.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BVALID <= 1'b0;
      O_BRESP <= `BEA_RESP_OKAY;
    end else if (I_CLK_EN) begin
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP <= mapped(aw_addr) ? `BEA_RESP_OKAY : `BEA_RESP_SLVERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: address taken and data answered on the same edge.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `BEA_RESP_OKAY;
    end else if (I_CLK_EN) begin
      O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP <= mapped({I_ARADDR[7:2], 2'b00}) ?
                   `BEA_RESP_OKAY : `BEA_RESP_SLVERR;
        case ({I_ARADDR[7:2], 2'b00})
          `BEA_OFF_CTRL: begin
            // Read strobe always reads zero; it only acts as a pulse.
            O_RDATA <= {26'h0, program_mode_bits, ready_irq_enable,
                        (unlock_cnt != 3'h0), busy, 1'b0};
          end
          `BEA_OFF_PTR: begin
            O_RDATA <= {{(32-ADDR_W){1'b0}}, byte_pointer_reg};
          end
          `BEA_OFF_VALUE: begin
            O_RDATA <= {24'h0, byte_value_reg};
          end
          default: begin
            O_RDATA <= 32'h0000_0000;
          end
        endcase
      end else if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // Pointer register, frozen while programming runs.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      byte_pointer_reg <= '0;
    end else if (wr_fire && w_lane0 && aw_addr == `BEA_OFF_PTR && !busy) begin
      byte_pointer_reg <= w_byte[ADDR_W-1:0];
    end
  end

  // Value register: software writes it, a read strobe loads it in the
  // same bus write, so the next access already sees the byte.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      byte_value_reg <= 8'h00;
    end else if (read_req) begin
      byte_value_reg <= mem[byte_pointer_reg];
    end else if (wr_fire && w_lane0 && aw_addr == `BEA_OFF_VALUE) begin
      byte_value_reg <= w_byte;
    end
  end

  // Interrupt enable and unlock window.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ready_irq_enable <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (I_CLK_EN) begin
      if (ctrl_wr) begin
        ready_irq_enable <= w_byte[`BEA_BIT_IRQ_EN];
      end
      // A fresh unlock write reopens the window; a start closes it, otherwise it runs out.
      if (ctrl_wr && w_byte[`BEA_BIT_UNLOCK]) begin
        unlock_cnt <= `BEA_UNLOCK_WINDOW;
      end else if (start_req) begin
        unlock_cnt <= 3'h0;
      end else if (unlock_cnt != 3'h0) begin
        unlock_cnt <= unlock_cnt - 3'h1;
      end
    end
  end

  // Core stall after a start or a read; a read wins the longer count.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      stall_cnt <= 3'h0;
    end else if (I_CLK_EN) begin
      if (read_req) begin
        stall_cnt <= `BEA_STALL_READ;
      end else if (start_req) begin
        stall_cnt <= `BEA_STALL_PROG;
      end else if (stall_cnt != 3'h0) begin
        stall_cnt <= stall_cnt - 3'h1;
      end
    end
  end

  // Mode bits live in the power-reset domain: a core reset only clears
  // them while the engine is idle, so a running job keeps its mode.
  always_ff @(posedge I_SYS_CLK or negedge I_PWR_NRST) begin
    if (!I_PWR_NRST) begin
      program_mode_bits <= `BEA_MODE_RESET;
    end else if (I_CLK_EN) begin
      if (!I_NRST) begin
        if (!busy) begin
          program_mode_bits <= `BEA_MODE_RESET;
        end
      end else if (ctrl_wr && !busy) begin
        program_mode_bits <= w_byte[`BEA_BIT_MODE_HI:`BEA_BIT_MODE_LO];
      end
    end
  end

  // Programming engine. It is reset by power only, so a core reset
  // cannot abort a job halfway through the cell.
  always_ff @(posedge I_SYS_CLK or negedge I_PWR_NRST) begin
    if (!I_PWR_NRST) begin
      eng_state <= BEA_ENG_IDLE;
      tick_cnt <= 20'h0;
      run_mode <= `BEA_MODE_ATOMIC;
      run_ptr <= '0;
      run_data <= 8'h00;
    end else if (I_CLK_EN) begin
      case (eng_state)
        BEA_ENG_IDLE: begin
          if (start_req && I_NRST) begin
            eng_state <= BEA_ENG_RUN;
            run_mode <= program_mode_bits;
            run_ptr <= byte_pointer_reg;
            run_data <= byte_value_reg;
            // Atomic covers erase and write in one interval.
            tick_cnt <= (program_mode_bits == `BEA_MODE_ATOMIC) ?
                        20'(ATOMIC_TICKS) : 20'(SINGLE_TICKS);
          end
        end
        BEA_ENG_RUN: begin
          // Time is measured in oscillator ticks, not core cycles.
          if (I_OSC_TICK) begin
            if (tick_cnt == 20'h1) begin
              eng_state <= BEA_ENG_IDLE;
            end
            tick_cnt <= tick_cnt - 20'h1;
          end
        end
        default: begin
          eng_state <= BEA_ENG_IDLE;
        end
      endcase
    end
  end

  // Cell update at the end of a job. Write-only can only clear bits,
  // which is why an unerased target ends up holding a mixed value.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_CLK_EN && busy && I_OSC_TICK && tick_cnt == 20'h1) begin
      case (run_mode)
        `BEA_MODE_ATOMIC: mem[run_ptr] <= run_data;
        `BEA_MODE_ERASE: mem[run_ptr] <= `BEA_ERASED_BYTE;
        `BEA_MODE_WRITE: mem[run_ptr] <= mem[run_ptr] & run_data;
        default: mem[run_ptr] <= mem[run_ptr];
      endcase
    end
  end

  // Core side outputs, all registered.
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CPU_STALL <= 1'b0;
      O_BUSY <= 1'b0;
      O_READY_IRQ <= 1'b0;
    end else if (I_CLK_EN) begin
      O_CPU_STALL <= (stall_cnt > 3'h1) || read_req || start_req;
      O_BUSY <= (eng_state == BEA_ENG_RUN) ? !(I_OSC_TICK &&
                tick_cnt == 20'h1) : start_req;
      O_READY_IRQ <= ready_irq_enable && !busy;
    end
  end

  // Checks.
  stall_prog_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST || !I_CLK_EN)
    start_req && !read_req |=> O_CPU_STALL ##1 O_CPU_STALL ##1 !O_CPU_STALL)
    else $error("program stall is not two cycles");
  stall_read_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST || !I_CLK_EN)
    read_req |=> O_CPU_STALL [*4] ##1 !O_CPU_STALL)
    else $error("read stall is not four cycles");
  unlock_clear_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST || !I_CLK_EN)
    ctrl_wr && w_byte[`BEA_BIT_UNLOCK] ##1 !ctrl_wr [*4] |=>
    unlock_cnt == 3'h0)
    else $error("unlock bit outlived its window");
  no_unlock_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST)
    unlock_cnt == 3'h0 && !busy |=> !busy)
    else $error("programming started without unlock");
  ptr_frozen_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST)
    busy && $past(busy) |-> $stable(byte_pointer_reg))
    else $error("pointer changed while busy");
  mode_frozen_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_PWR_NRST || !I_NRST)
    busy |=> $stable(program_mode_bits))
    else $error("mode changed while busy");
  read_load_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST)
    read_req |=> byte_value_reg == mem[$past(byte_pointer_reg)])
    else $error("read did not load the value register");
  busy_hold_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_PWR_NRST)
    busy && tick_cnt > 20'h1 |=> busy)
    else $error("busy dropped before the time elapsed");
  ready_irq_a: assert property (@(posedge I_SYS_CLK)
    disable iff (!I_NRST || !I_CLK_EN)
    ##1 O_READY_IRQ == ($past(ready_irq_enable) && !$past(busy)))
    else $error("ready request does not follow idle state");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the byte EEPROM access control block.
`include "bea_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short programming times keep the run brief; long enough to poke at busy.
  localparam int AT = 60;
  localparam int ST = 30;
  // Bench-driven inputs, all given a value at time zero.
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pwr_nrst = 1'b0;
  logic osc = 1'b1;
  logic half_rate = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  // Outputs of the block.
  wire logic awready, wready, bvalid, arready, rvalid, stall, busy, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  // Counters and captured bus answers.
  int failures = 0;
  int tests_run = 0;
  int busy_cnt = 0;
  int stall_cnt = 0;
  int k;
  logic [31:0] rd_val;
  logic [1:0] rd_resp, wr_resp;

  // The 8 ns clock of the core.
  always #4 clk = ~clk;

  // Oscillator ticks run every cycle, or every other one when slowed.
  always @(posedge clk) begin
    osc <= half_rate ? ~osc : 1'b1;
  end

  // Count cycles of busy and core stall as seen at each edge.
  always @(posedge clk) begin
    if (busy === 1'b1) busy_cnt++;
    if (stall === 1'b1) stall_cnt++;
  end

  bea_top #(.ATOMIC_TICKS(AT), .SINGLE_TICKS(ST)) dut (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_PWR_NRST(pwr_nrst),
    .I_CLK_EN(1'b1), .I_OSC_TICK(osc),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(4'hf), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_CPU_STALL(stall), .O_BUSY(busy),
    .O_READY_IRQ(irq)
  );

  // Prints the verdict; the only place the run ends.
  task tally_and_finish;
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task timed_out;
    failures++;
    tally_and_finish();
  endtask

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One AXI4-Lite write; called just after a rising edge.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      // Response ready rises once the data is taken, so two calls in a
      // row never lower and raise it within one time step.
      if (wready === 1'b1) begin
        wvalid <= 1'b0;
        bready <= 1'b1;
      end
      if (bvalid === 1'b1) break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    if (n == 100) timed_out();
  endtask

  // One AXI4-Lite read; data and response land in rd_val and rd_resp.
  task rd(input logic [7:0] a);
    int n;
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      // Read ready rises with the address handshake, for the same reason.
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
      if (rvalid === 1'b1) break;
    end
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    if (n == 100) timed_out();
  endtask

  // Waits for a programming job to finish, bounded.
  task settle;
    int n;
    repeat (4) @(posedge clk);
    for (n = 0; n < 2000 && busy === 1'b1; n++) @(posedge clk);
    if (n == 2000) timed_out();
  endtask

  // Strobe-reads the byte at p; the stall count is left for the caller.
  task fetch(input logic [7:0] p);
    wr(`BEA_OFF_PTR, {24'h0, p});
    stall_cnt = 0;
    wr(`BEA_OFF_CTRL, 32'h01);
    repeat (6) @(posedge clk);
    rd(`BEA_OFF_VALUE);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    pwr_nrst <= 1'b1;
    @(posedge clk);
    rd(`BEA_OFF_CTRL);
    check("ctrl at reset", rd_val, 32'h0);
    rd(8'h0c);
    check("unmapped read resp", {30'h0, rd_resp}, 32'h2);
    wr(8'h0c, 32'h55);
    check("unmapped write resp", {30'h0, wr_resp}, 32'h2);
    // Atomic job, then try to disturb it while it runs.
    wr(`BEA_OFF_PTR, 32'h05);
    wr(`BEA_OFF_VALUE, 32'h3c);
    busy_cnt = 0;
    stall_cnt = 0;
    wr(`BEA_OFF_CTRL, 32'h04);
    wr(`BEA_OFF_CTRL, 32'h02);
    repeat (4) @(posedge clk);
    check("start stall", 32'(stall_cnt), 32'h2);
    rd(`BEA_OFF_CTRL);
    check("busy bit", {31'h0, rd_val[1]}, 32'h1);
    wr(`BEA_OFF_PTR, 32'h09);
    wr(`BEA_OFF_CTRL, 32'h21);
    rd(`BEA_OFF_VALUE);
    check("value kept", rd_val, 32'h3c);
    wr(`BEA_OFF_CTRL, 32'h04);
    wr(`BEA_OFF_CTRL, 32'h02);
    settle();
    check("atomic busy time", 32'(busy_cnt), 32'(AT));
    rd(`BEA_OFF_CTRL);
    check("ctrl after job", rd_val, 32'h0);
    rd(`BEA_OFF_PTR);
    check("pointer kept", rd_val, 32'h05);
    fetch(8'h05);
    check("read stall", 32'(stall_cnt), 32'h4);
    check("atomic data", rd_val, 32'h3c);
    // Erase only, with the ready request enabled.
    busy_cnt = 0;
    wr(`BEA_OFF_CTRL, 32'h1c);
    wr(`BEA_OFF_CTRL, 32'h1a);
    repeat (2) @(posedge clk);
    check("irq while busy", {31'h0, irq}, 32'h0);
    settle();
    @(posedge clk);
    check("irq when ready", {31'h0, irq}, 32'h1);
    check("erase busy time", 32'(busy_cnt), 32'(ST));
    fetch(8'h05);
    check("erased byte", rd_val, 32'hff);
    // Write only on the erased byte, oscillator slowed to half rate.
    wr(`BEA_OFF_VALUE, 32'ha5);
    busy_cnt = 0;
    half_rate <= 1'b1;
    wr(`BEA_OFF_CTRL, 32'h24);
    wr(`BEA_OFF_CTRL, 32'h22);
    settle();
    half_rate <= 1'b0;
    check("slow tick time", 32'(busy_cnt >= 2 * ST - 1 &&
          busy_cnt <= 2 * ST + 1), 32'h1);
    fetch(8'h05);
    check("write-only data", rd_val, 32'ha5);
    // Starts that must be refused: no unlock, late start, reserved mode.
    busy_cnt = 0;
    wr(`BEA_OFF_CTRL, 32'h02);
    repeat (8) @(posedge clk);
    wr(`BEA_OFF_CTRL, 32'h04);
    repeat (8) @(posedge clk);
    wr(`BEA_OFF_CTRL, 32'h02);
    wr(`BEA_OFF_CTRL, 32'h34);
    wr(`BEA_OFF_CTRL, 32'h32);
    repeat (8) @(posedge clk);
    check("refused starts", 32'(busy_cnt), 32'h0);
    // Core reset in mid-job must not stop the programming.
    wr(`BEA_OFF_PTR, 32'h07);
    wr(`BEA_OFF_VALUE, 32'h11);
    wr(`BEA_OFF_CTRL, 32'h04);
    wr(`BEA_OFF_CTRL, 32'h02);
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 100; k++) begin
      rd(`BEA_OFF_CTRL);
      if (rd_val[1] === 1'b0) break;
    end
    if (k == 100) timed_out();
    fetch(8'h07);
    check("data after reset", rd_val, 32'h11);
    tally_and_finish();
  end
endmodule
`default_nettype wire
